/* rtl/dp_slave_defs.vh */
// Purpose: Constants for the fieldbus drive process data slave
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Offsets, fields, reset values and timing counts
`ifndef DP_SLAVE_DEFS_VH
`define DP_SLAVE_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_REACT_MODE 8'h04
`define OFS_ERR_TIMER 8'h08
`define OFS_FORMAT_SEL 8'h0C
`define OFS_NODE_ADDR 8'h10
`define OFS_STATUS 8'h14
`define OFS_VERSION 8'h18
`define OFS_CTRL_RX 8'h1C
`define OFS_SPEED_REF 8'h20
`define OFS_ACT_SPEED 8'h24
`define OFS_MASTER_ADDR 8'h28
`define OFS_WR_ASSIGN0 8'h40
`define OFS_RD_ASSIGN0 8'h50

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define NODE_ADDR_MAX 8'd125
`define REACT_MODE_MAX 4'hF
`define REACT_MODE_RST 4'h0
// Timer in tenths of a second, 60.0 s top
`define ERR_TIMER_MAX 10'd600
`define ERR_TIMER_RST 10'd0
`define FORMAT_SEL_RST 8'h00
`define NODE_ADDR_RST 8'h00
`define ASSIGN_RST 16'h0000
`define FW_VERSION 16'h0123

// ----------------------------------------
// Telegram formats and words
// ----------------------------------------
`define FMT_1 2'd0
`define FMT_2 2'd1
`define FMT_3 2'd2
`define FMT_4 2'd3
`define CTRL_VALID_HI 8'h04
`define CTRL_READY_LO 8'h7E
`define CTRL_RUN_LO 8'h7F
`define STAT_HI_SRC 8'h02
`define STAT_LO_NOT_READY 8'h40
`define STAT_LO_READY 8'h31
`define STAT_LO_RUN 8'h37
`define SPEED_FULL 16'h4000
`define ADDR_ERR_CODE 8'h05

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
// Error indicator flash half period in ms
`define FLASH_MS 250
`define FLASH_CYCLES (`FLASH_MS * 1000 * `CLK_MHZ)

`endif

/* rtl/assign_table.v */
// Purpose: Eight 16-bit cyclic parameter assignment slots
// Assumes: One write port, one registered read port
// Notes: Slots 0-3 write assignments, 4-7 read assignments
`timescale 1ns/1ns
`include "dp_slave_defs.vh"
module assign_table (
  input wire aclk,
  input wire aresetn,
  input wire we,
  input wire [2:0] waddr,
  input wire [15:0] wdata,
  input wire [2:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:7];
  integer i;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem[i] <= `ASSIGN_RST;
      end
      rdata <= 16'h0000;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

/* rtl/dp_slave.v */
// Purpose: Fieldbus slave process data and configuration of a drive card
// Assumes: Frames arrive already decoded as words with a one-cycle strobe
// Notes: Configuration over AXI4-Lite; format and address latch at reset
// Overview of operation
// - Address 0-125 legal; 126 or above flags error, flashes indicator, reports code
// - Stored address used only when both rotary switches read 00
// - Error reaction mode 0-15, reset default 0
// - Error timer 0.0 s to 60.0 s, default 0.0 s
// - Four write assignment slots, default 0, active in formats 2 or 4 only; the slots here are writable in every format
// - Four read assignment slots, 16-bit, default 0
// - Firmware version readable as four-digit decimal
// - New format selection applies only after next power cycle; here reset also clears the selection, so format 1 always applies
// - Master and slave must share node address or no exchange
// - Correct configuration brings link up, indicators green
// - Control word bit 0 commands run on or off
// - Speed reference 4000 hex equals maximum frequency
// - Actual speed scaled alike, returned with status word
// - After power-up status 02 40 and actual speed 0000
// - Selection 0,1,6-255 format 1; 2,5 format 2; 3; 4
// - High byte 04 validates; 7E ready request; 7F run request
// - Negative speed reference means reverse; actual speed signed alike
// - Status low byte 31 when ready, 37 while running
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dp_slave_defs.vh"
module dp_slave (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] address_switch_high,
  input wire [3:0] address_switch_low,
  input wire frame_valid,
  input wire [6:0] frame_dest_addr,
  input wire [15:0] control_word,
  input wire [15:0] speed_reference,
  input wire [15:0] drive_actual_speed,
  output reg [15:0] status_word,
  output reg [15:0] actual_speed,
  output reg run_request,
  output reg reverse_cmd,
  output reg [15:0] speed_cmd,
  output reg power_indicator,
  output reg online_indicator,
  output reg error_indicator,
  output reg [7:0] error_code,
  output reg [1:0] active_format
);
  // ----------------------------------------
  // Drive states
  // ----------------------------------------
  localparam ST_NOT_READY = 3'b001;
  localparam ST_READY = 3'b010;
  localparam ST_RUN = 3'b100;

  function [1:0] fmt_decode;
    input [7:0] sel;
    begin
      case (sel)
        8'd2, 8'd5: fmt_decode = `FMT_2;
        8'd3: fmt_decode = `FMT_3;
        8'd4: fmt_decode = `FMT_4;
        default: fmt_decode = `FMT_1;
      endcase
    end
  endfunction

  reg [3:0] react_mode_q;
  reg [9:0] err_timer_q;
  reg [7:0] format_sel_q;
  reg [7:0] node_addr_q;
  reg [2:0] state_q;
  reg boot_q;
  reg [7:0] eff_addr_q;
  reg addr_err_q;
  reg [31:0] flash_cnt_q;
  reg [15:0] ctrl_rx_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg rd_pend_q;
  reg [7:0] rd_addr_q;
  wire [15:0] tbl_rdata;
  wire wr_fire;
  wire tbl_we;
  wire [31:0] wv;
  wire [7:0] sw_addr;
  wire frame_ok;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wv = w_data_q;
  assign tbl_we = wr_fire && (aw_addr_q[7:6] == 2'b01) && !aw_addr_q[5]
    && (aw_addr_q[1:0] == 2'b00) && (w_strb_q[1:0] == 2'b11);
  assign sw_addr = {address_switch_high, 4'h0} + {4'h0, address_switch_low};
  assign frame_ok = frame_valid && !addr_err_q && !boot_q
    && ({1'b0, frame_dest_addr} == eff_addr_q);

  assign_table u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(tbl_we),
    .waddr(aw_addr_q[4:2]),
    .wdata(wv[15:0]),
    .raddr(s_axi_araddr[4:2]),
    .rdata(tbl_rdata)
  );

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      react_mode_q <= `REACT_MODE_RST;
      err_timer_q <= `ERR_TIMER_RST;
      format_sel_q <= `FORMAT_SEL_RST;
      node_addr_q <= `NODE_ADDR_RST;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr_q)
          `OFS_REACT_MODE: if (w_strb_q[0]) react_mode_q <= wv[3:0];
          `OFS_ERR_TIMER: begin
            // Out of range timer values clamp rather than wrap
            if (w_strb_q[1:0] == 2'b11) begin
              err_timer_q <= (wv[15:0] > {6'h00, `ERR_TIMER_MAX}) ? `ERR_TIMER_MAX
                : wv[9:0];
            end
          end
          `OFS_FORMAT_SEL: if (w_strb_q[0]) format_sel_q <= wv[7:0];
          `OFS_NODE_ADDR: if (w_strb_q[0]) node_addr_q <= wv[7:0];
          default: begin
            if (aw_addr_q[7:6] != 2'b01 || aw_addr_q[5] || aw_addr_q[1:0] != 2'b00) begin
              s_axi_bresp <= 2'b10;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !rd_pend_q && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Wait one cycle so the table read register holds the slot
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (rd_addr_q)
          `OFS_CTRL: s_axi_rdata <= {22'h0, active_format, 3'b000, state_q, addr_err_q,
            online_indicator};
          `OFS_REACT_MODE: s_axi_rdata <= {28'h0, react_mode_q};
          `OFS_ERR_TIMER: s_axi_rdata <= {22'h0, err_timer_q};
          `OFS_FORMAT_SEL: s_axi_rdata <= {24'h0, format_sel_q};
          `OFS_NODE_ADDR: s_axi_rdata <= {24'h0, eff_addr_q};
          `OFS_STATUS: s_axi_rdata <= {16'h0, status_word};
          `OFS_VERSION: s_axi_rdata <= {16'h0, `FW_VERSION};
          `OFS_CTRL_RX: s_axi_rdata <= {16'h0, ctrl_rx_q};
          `OFS_SPEED_REF: s_axi_rdata <= {16'h0, speed_cmd};
          `OFS_ACT_SPEED: s_axi_rdata <= {16'h0, actual_speed};
          `OFS_MASTER_ADDR: s_axi_rdata <= {24'h0, error_code};
          default: begin
            if (rd_addr_q[7:6] == 2'b01 && !rd_addr_q[5] && rd_addr_q[1:0] == 2'b00) begin
              s_axi_rdata <= {16'h0, tbl_rdata};
            end else begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= 2'b10;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Power-up latch of address and format
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= 1'b1;
      eff_addr_q <= 8'h00;
      addr_err_q <= 1'b0;
      active_format <= `FMT_1;
      error_code <= 8'h00;
      power_indicator <= 1'b0;
    end else begin
      power_indicator <= 1'b1;
      // Only reset reloads these, and it also clears the stored format and address, so later writes are never used
      if (boot_q) begin
        boot_q <= 1'b0;
        active_format <= fmt_decode(format_sel_q);
        if (address_switch_high == 4'h0 && address_switch_low == 4'h0) begin
          eff_addr_q <= node_addr_q;
          addr_err_q <= (node_addr_q > `NODE_ADDR_MAX);
          error_code <= (node_addr_q > `NODE_ADDR_MAX) ? `ADDR_ERR_CODE : 8'h00;
        end else begin
          eff_addr_q <= sw_addr;
          addr_err_q <= (sw_addr > `NODE_ADDR_MAX);
          error_code <= (sw_addr > `NODE_ADDR_MAX) ? `ADDR_ERR_CODE : 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // Error indicator flash
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt_q <= 32'h00000000;
      error_indicator <= 1'b0;
    end else if (addr_err_q) begin
      if (flash_cnt_q == `FLASH_CYCLES - 1) begin
        flash_cnt_q <= 32'h00000000;
        error_indicator <= !error_indicator;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h00000001;
      end
    end else begin
      error_indicator <= 1'b0;
    end
  end

  // ----------------------------------------
  // Cyclic process data exchange
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_NOT_READY;
      ctrl_rx_q <= 16'h0000;
      status_word <= {`STAT_HI_SRC, `STAT_LO_NOT_READY};
      actual_speed <= 16'h0000;
      run_request <= 1'b0;
      reverse_cmd <= 1'b0;
      speed_cmd <= 16'h0000;
      online_indicator <= 1'b0;
    end else begin
      if (frame_ok) begin
        online_indicator <= 1'b1;
        ctrl_rx_q <= control_word;
        if (control_word[15:8] == `CTRL_VALID_HI || control_word[15:8] == 8'h0C) begin
          speed_cmd <= speed_reference;
          // Reverse when exactly one of control bit 11 and a negative reference is set
          reverse_cmd <= control_word[11] ^ speed_reference[15];
          case (state_q)
            ST_NOT_READY: begin
              if (control_word[7:0] == `CTRL_READY_LO) state_q <= ST_READY;
            end
            ST_READY: begin
              if (control_word[7:0] == `CTRL_RUN_LO) state_q <= ST_RUN;
            end
            ST_RUN: begin
              if (!control_word[0]) state_q <= ST_READY;
            end
            default: state_q <= ST_NOT_READY;
          endcase
          if (control_word[7]) state_q <= ST_NOT_READY;
        end
      end
      run_request <= (state_q == ST_RUN);
      case (state_q)
        ST_READY: status_word <= {`STAT_HI_SRC, `STAT_LO_READY};
        ST_RUN: status_word <= {`STAT_HI_SRC, `STAT_LO_RUN};
        default: status_word <= {`STAT_HI_SRC, `STAT_LO_NOT_READY};
      endcase
      // Drive speed already uses the signed 4000 hex full-scale
      actual_speed <= (state_q == ST_NOT_READY) ? 16'h0000 : drive_actual_speed;
    end
  end
endmodule

/* tb/dp_slave_properties.sv */
// Purpose: Port-level checks of dp_slave
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every dp_slave instance
`timescale 1ns/1ns
module dp_slave_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [15:0] status_word,
  input wire [15:0] actual_speed,
  input wire run_request,
  input wire power_indicator,
  input wire online_indicator,
  input wire error_indicator,
  input wire [7:0] error_code
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_status: assert property ($rose(aresetn) |-> status_word == 16'h0240
    && actual_speed == 16'h0000) else $error("Status not at power-up value");
  chk_status_high: assert property (status_word[15:8] == 8'h02)
    else $error("Status high byte wrong");
  // Two cycles of status so the one-cycle status lag cannot trip it
  chk_idle_speed: assert property (status_word[7:0] == 8'h40 && $past(status_word[7:0]) == 8'h40
    |-> actual_speed == 16'h0000 && !run_request) else $error("Idle drive not stopped");
  chk_run_status: assert property (status_word[7:0] == 8'h37 && $past(status_word[7:0]) == 8'h37
    |-> run_request) else $error("Running without run request");
  chk_power_on: assert property (aresetn && $past(aresetn) |-> power_indicator)
    else $error("Power indicator off");
  chk_err_code: assert property (error_code == 8'h00 || error_code == 8'h05)
    else $error("Bad error code");
  chk_err_offline: assert property (error_code == 8'h05 |-> !online_indicator)
    else $error("Online with address error");
  chk_flash_err: assert property (error_code != 8'h05 |-> !error_indicator)
    else $error("Error indicator lit without address error");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("Write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("Read data late");
  cover property (status_word[7:0] == 8'h37);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (error_code == 8'h05);
endmodule
bind dp_slave dp_slave_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .status_word(status_word), .actual_speed(actual_speed),
  .run_request(run_request), .power_indicator(power_indicator),
  .online_indicator(online_indicator), .error_indicator(error_indicator),
  .error_code(error_code));

/* tb/dp_master_model.sv */
// Purpose: Fieldbus master that sends decoded frames
// Assumes: Simple telegram format, one frame per call
// Notes: Payload lines carry junk between frames
`timescale 1ns/1ns
module dp_master_model (
  input wire aclk,
  output reg frame_valid,
  output reg [6:0] frame_dest_addr,
  output reg [15:0] control_word,
  output reg [15:0] speed_reference
);
  initial begin
    frame_valid = 1'b0;
    frame_dest_addr = 7'h00;
    control_word = 16'h0000;
    speed_reference = 16'h0000;
  end
  task send(input [6:0] a, input [15:0] c, input [15:0] s);
    begin
      @(posedge aclk);
      frame_valid <= 1'b1;
      frame_dest_addr <= a;
      control_word <= c;
      speed_reference <= s;
      @(posedge aclk);
      frame_valid <= 1'b0;
      frame_dest_addr <= ~a;
      control_word <= ~c;
      speed_reference <= ~s;
    end
  endtask
endmodule

/* tb/fieldbus_drive_process_data_slave_tb.sv */
// Purpose: Self-checking bench of dp_slave
// Assumes: 125 MHz clock, AXI4-Lite master tasks
// Notes: Settings only latch at reset, so scenarios reset between setups
`timescale 1ns/1ns
`include "dp_slave_defs.vh"
module fieldbus_drive_process_data_slave_tb;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb, address_switch_high, address_switch_low;
  reg [15:0] drive_actual_speed;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, active_format;
  wire [31:0] s_axi_rdata;
  wire frame_valid, run_request, reverse_cmd, power_indicator, online_indicator, error_indicator;
  wire [6:0] frame_dest_addr;
  wire [15:0] control_word, speed_reference, status_word, actual_speed, speed_cmd;
  wire [7:0] error_code;
  integer miscompares, samples_checked, i;
  reg [31:0] d;
  reg [1:0] r;
  dp_slave u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .address_switch_high(address_switch_high),
    .address_switch_low(address_switch_low), .frame_valid(frame_valid),
    .frame_dest_addr(frame_dest_addr), .control_word(control_word),
    .speed_reference(speed_reference), .drive_actual_speed(drive_actual_speed),
    .status_word(status_word), .actual_speed(actual_speed), .run_request(run_request),
    .reverse_cmd(reverse_cmd), .speed_cmd(speed_cmd), .power_indicator(power_indicator),
    .online_indicator(online_indicator), .error_indicator(error_indicator),
    .error_code(error_code), .active_format(active_format));
  dp_master_model u_master (.aclk(aclk), .frame_valid(frame_valid),
    .frame_dest_addr(frame_dest_addr), .control_word(control_word),
    .speed_reference(speed_reference));
  // ----
  // Helpers
  // ----
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] v);
    begin
      r = 2'b11;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Wait until the response arrives; the watchdog ends a wait that never does
      while (r === 2'b11) begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) r = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    begin
      r = 2'b11;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (r === 2'b11) begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) begin
          r = s_axi_rresp;
          d = s_axi_rdata;
        end
      end
      s_axi_rready <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      axi_rd(a);
      cmp(d, exp);
    end
  endtask
  task do_reset(input [3:0] h, input [3:0] l);
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      address_switch_high <= h;
      address_switch_low <= l;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
    end
  endtask
  task frame(input [6:0] a, input [15:0] c, input [15:0] s);
    begin
      u_master.send(a, c, s);
      repeat (4) @(posedge aclk);
    end
  endtask
  task stop_test;
    begin
      $display("checked %0d, miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_defaults;
    begin
      cmp(status_word, 16'h0240);
      cmp(actual_speed, 16'h0000);
      cmp(active_format, `FMT_1);
      cmp(power_indicator, 1'b1);
      rd_chk(`OFS_REACT_MODE, `REACT_MODE_RST);
      rd_chk(`OFS_ERR_TIMER, `ERR_TIMER_RST);
      rd_chk(`OFS_FORMAT_SEL, `FORMAT_SEL_RST);
      rd_chk(`OFS_NODE_ADDR, `NODE_ADDR_RST);
      rd_chk(`OFS_WR_ASSIGN0, `ASSIGN_RST);
      rd_chk(`OFS_RD_ASSIGN0 + 8'h0C, `ASSIGN_RST);
      rd_chk(`OFS_VERSION, `FW_VERSION);
      $display("t_defaults done");
    end
  endtask
  task t_regs;
    begin
      axi_wr(`OFS_REACT_MODE, 32'h0000000F);
      rd_chk(`OFS_REACT_MODE, 32'h0000000F);
      // Above 60.0 s the timer saturates rather than wrapping
      axi_wr(`OFS_ERR_TIMER, 32'd700);
      rd_chk(`OFS_ERR_TIMER, 32'd600);
      axi_wr(`OFS_WR_ASSIGN0 + 8'h0C, 32'h0000FFFF);
      rd_chk(`OFS_WR_ASSIGN0 + 8'h0C, 32'h0000FFFF);
      axi_wr(`OFS_RD_ASSIGN0, 32'h0000A5C3);
      rd_chk(`OFS_RD_ASSIGN0, 32'h0000A5C3);
      axi_wr(`OFS_VERSION, 32'h00009999);
      rd_chk(`OFS_VERSION, `FW_VERSION);
      // Unmapped offset above the slots must neither alias nor write a slot
      axi_wr(8'h60, 32'h00000001);
      cmp(r, 2'b10);
      rd_chk(8'h60, 32'h00000000);
      cmp(r, 2'b10);
      rd_chk(`OFS_WR_ASSIGN0, `ASSIGN_RST);
      $display("t_regs done");
    end
  endtask
  task t_format;
    begin
      for (i = 1; i < 7; i = i + 1) begin
        axi_wr(`OFS_FORMAT_SEL, i);
        rd_chk(`OFS_FORMAT_SEL, i);
        cmp(active_format, `FMT_1);
      end
      $display("t_format done");
    end
  endtask
  task t_link;
    begin
      do_reset(4'h1, 4'h2);
      drive_actual_speed <= 16'h1234;
      rd_chk(`OFS_NODE_ADDR, 32'h00000012);
      frame(7'h13, 16'h047E, 16'h4000);
      cmp(status_word, 16'h0240);
      frame(7'h12, 16'h007E, 16'h4000);
      cmp(status_word, 16'h0240);
      frame(7'h12, 16'h047E, 16'h4000);
      cmp(status_word, 16'h0231);
      cmp(online_indicator, 1'b1);
      cmp(error_indicator, 1'b0);
      frame(7'h12, 16'h047F, 16'h4000);
      cmp(status_word, 16'h0237);
      cmp(run_request, 1'b1);
      cmp(speed_cmd, 16'h4000);
      cmp(actual_speed, 16'h1234);
      frame(7'h12, 16'h047F, 16'hE000);
      cmp(reverse_cmd, 1'b1);
      cmp(speed_cmd, 16'hE000);
      frame(7'h12, 16'h047E, 16'h4000);
      cmp(status_word, 16'h0231);
      cmp(run_request, 1'b0);
      frame(7'h12, 16'h0480, 16'h0000);
      cmp(status_word, 16'h0240);
      $display("t_link done");
    end
  endtask
  task t_addr_err;
    begin
      do_reset(4'h7, 4'hE);
      cmp(error_code, `ADDR_ERR_CODE);
      frame(7'h7E, 16'h047E, 16'h0000);
      cmp(status_word, 16'h0240);
      cmp(online_indicator, 1'b0);
      do_reset(4'h7, 4'hD);
      cmp(error_code, 8'h00);
      $display("t_addr_err done");
    end
  endtask
  initial begin
    miscompares = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    {address_switch_high, address_switch_low} = 8'h00;
    drive_actual_speed = 16'h0000;
    do_reset(4'h0, 4'h0);
    t_defaults;
    t_regs;
    t_format;
    t_link;
    t_addr_err;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule
